// file: pcm_motor_core.sv
// pidf closed-loop motor core with sensor decoding and axi4-lite registers
// Functional notes
// - quadrature position counts every edge of both phases, four per cycle
// - velocity is position change over each 100 ms window, all sensors
// - potentiometer position is the unsigned 10-bit converter reading
// - analog encoder position unwraps, 1023 to 0 continues to 1024
// - rising-edge mode counts rising edges of phase A
// - throttle is signed, -1023 full reverse, +1023 full forward
// - open-loop ramp limits throttle change per 10 ms step
// - loop slew limit bounds loop output change per 1 ms pass
// - nonzero slew limit steps toward clamped, inverted output, zero passes it
// - error outside nonzero integral window clears sum, else accumulates
// - loop update including integral runs once every 1 ms
// - first pass zeroes integral and delta, slews from current throttle
// - loop error is target minus measurement, kept visible
// - error delta is error minus previous error, then error saved
// - output sums P and D terms, I term only when both nonzero
// - feed-forward adds signed gain times target
// - positive-only sensor clamps negative unramped output to zero
// - output inversion negates after clamp, before slew limiting
// - sensor inversion negates position and velocity before use
// - follower with output inversion drives opposite to leader
`timescale 1ns/1ps
module pcm_motor_core
#(
	parameter int unsigned LOOP_CYCLES = pcm_pkg::LOOP_CYCLES,
	parameter int unsigned RAMP_CYCLES = pcm_pkg::RAMP_CYCLES,
	parameter int unsigned VEL_CYCLES  = pcm_pkg::VEL_CYCLES
)
(
	// clock and reset
	input  logic        ref_clk,
	input  logic        rst,
	// axi4-lite write address and data
	input  logic [7:0]  s_axi_awaddr,
	input  logic        s_axi_awvalid,
	output logic        s_axi_awready,
	input  logic [31:0] s_axi_wdata,
	input  logic [3:0]  s_axi_wstrb,
	input  logic        s_axi_wvalid,
	output logic        s_axi_wready,
	// axi4-lite write response
	output logic [1:0]  s_axi_bresp,
	output logic        s_axi_bvalid,
	input  logic        s_axi_bready,
	// axi4-lite read
	input  logic [7:0]  s_axi_araddr,
	input  logic        s_axi_arvalid,
	output logic        s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0]  s_axi_rresp,
	output logic        s_axi_rvalid,
	input  logic        s_axi_rready,
	// feedback sensors
	input  logic        quadAPin,
	input  logic        quadBPin,
	input  logic [9:0]  adcData,
	input  logic        adcValid,
	// leader throttle for follower mode
	input  logic [10:0] leaderThrottle,
	// motor bridge command and loop observation
	output logic [10:0] throttle,
	output logic [31:0] loopError,
	output logic        loopTick
);

	function automatic logic signed [47:0] mulGain(
		input logic signed [31:0] v,
		input logic signed [16:0] g);
		logic signed [47:0] a;
		logic signed [47:0] b;
		a = 48'(v);
		b = 48'(g);
		return a * b;
	endfunction: mulGain

	function automatic logic signed [31:0] sat32(input logic signed [47:0] v);
		logic signed [31:0] r;
		r = 32'(v);
		if (v > pcm_pkg::S32_MAX)
			r = 32'(pcm_pkg::S32_MAX);
		else if (v < pcm_pkg::S32_MIN)
			r = 32'(pcm_pkg::S32_MIN);
		return r;
	endfunction: sat32

	function automatic logic signed [10:0] satThrot(
		input logic signed [32:0] v);
		logic signed [10:0] r;
		r = 11'(v);
		if (v > 33'(pcm_pkg::THROT_MAX))
			r = 11'(pcm_pkg::THROT_MAX);
		else if (v < 33'(-pcm_pkg::THROT_MAX))
			r = 11'(-pcm_pkg::THROT_MAX);
		return r;
	endfunction: satThrot

	// step dividers
	logic [31:0] loopCnt_r;
	logic [31:0] rampCnt_r;
	logic [31:0] velCnt_r;
	logic        rampTick;
	logic        velTick;

	assign loopTick = loopCnt_r == 32'(LOOP_CYCLES - 1);
	assign rampTick = rampCnt_r == 32'(RAMP_CYCLES - 1);
	assign velTick  = velCnt_r == 32'(VEL_CYCLES - 1);

	always_ff @(posedge ref_clk)
	begin
		if (rst || loopTick)
			loopCnt_r <= '0;
		else
			loopCnt_r <= loopCnt_r + 32'h1;
		if (rst || rampTick)
			rampCnt_r <= '0;
		else
			rampCnt_r <= rampCnt_r + 32'h1;
		if (rst || velTick)
			velCnt_r <= '0;
		else
			velCnt_r <= velCnt_r + 32'h1;
	end

	// register file and control fields
	logic [31:0] cfgR [0:pcm_pkg::LAST_RW_IDX];
	logic [31:0] regView [0:pcm_pkg::REG_NUM-1];
	pcm_pkg::pcm_mode_e   mode;
	pcm_pkg::pcm_sensor_e sensor;
	logic        sensInv;
	logic        outInv;
	logic        posOnly;
	logic        loopMode;
	logic        reinit;

	assign mode     = pcm_pkg::pcm_mode_e'(
		cfgR[0][pcm_pkg::CTRL_MODE_LSB +: 2]);
	assign sensor   = pcm_pkg::pcm_sensor_e'(
		cfgR[0][pcm_pkg::CTRL_SENS_LSB +: 2]);
	assign sensInv  = cfgR[0][pcm_pkg::CTRL_SENS_INV];
	assign outInv   = cfgR[0][pcm_pkg::CTRL_OUT_INV];
	assign posOnly  = cfgR[0][pcm_pkg::CTRL_POS_ONLY];
	assign loopMode = (mode == pcm_pkg::MODE_POSITION)
		|| (mode == pcm_pkg::MODE_VELOCITY);

	// sensor decode
	logic [1:0]         quadLvl;
	logic [1:0]         quadPrev_r;
	logic signed [31:0] quadPos_r;
	logic signed [31:0] risePos_r;
	logic signed [31:0] analogPos_r;
	logic [9:0]         adcRaw_r;
	logic               adcSeen_r;
	logic               stepUp;
	logic               stepDn;
	logic               riseA;
	logic [9:0]         adcDiff;
	logic signed [31:0] rawPos;
	logic signed [31:0] sensPos;
	logic signed [31:0] velBase_r;
	logic signed [31:0] vel_r;

	pcm_pin_sync #(.WIDTH(2)) uQuadSync
	(
		.clk    (ref_clk),
		.rst    (rst),
		.pinIn  ({quadBPin, quadAPin}),
		.pinOut (quadLvl)
	);

	assign stepUp  = quadLvl[0] ^ quadPrev_r[1];
	assign stepDn  = quadLvl[1] ^ quadPrev_r[0];
	assign riseA   = quadLvl[0] && !quadPrev_r[0];
	assign adcDiff = adcData - adcRaw_r;

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			quadPrev_r  <= '0;
			quadPos_r   <= '0;
			risePos_r   <= '0;
		end
		else
		begin
			quadPrev_r <= quadLvl;
			if (stepUp && !stepDn)
				quadPos_r <= quadPos_r + 32'sh1;
			else if (stepDn && !stepUp)
				quadPos_r <= quadPos_r - 32'sh1;
			if (riseA)
				risePos_r <= risePos_r + 32'sh1;
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			adcRaw_r    <= '0;
			adcSeen_r   <= 1'b0;
			analogPos_r <= '0;
		end
		else if (adcValid)
		begin
			adcRaw_r  <= adcData;
			adcSeen_r <= 1'b1;
			if (adcSeen_r)
				analogPos_r <= analogPos_r + 32'($signed(adcDiff));
			else
				analogPos_r <= $signed({22'h0, adcData});
		end
	end

	always_comb
	begin
		case (sensor)
			pcm_pkg::SENS_QUAD:   rawPos = quadPos_r;
			pcm_pkg::SENS_RISE:   rawPos = risePos_r;
			pcm_pkg::SENS_POT:    rawPos = $signed({22'h0, adcRaw_r});
			pcm_pkg::SENS_ANALOG: rawPos = analogPos_r;
			default:              rawPos = quadPos_r;
		endcase
	end

	assign sensPos = sensInv ? -rawPos : rawPos;

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			velBase_r <= '0;
			vel_r     <= '0;
		end
		else if (velTick)
		begin
			vel_r     <= sensPos - velBase_r;
			velBase_r <= sensPos;
		end
	end

	// closed-loop pass
	logic signed [31:0] target;
	logic signed [31:0] measured;
	logic signed [31:0] err;
	logic signed [31:0] absErr;
	logic signed [31:0] integral_sum_r;
	logic signed [31:0] previous_error_r;
	logic signed [31:0] error_delta_r;
	logic signed [31:0] error_r;
	logic signed [32:0] loopOut_r;
	logic               primed_flag_r;
	logic signed [31:0] iNxt;
	logic signed [31:0] dNxt;
	logic signed [47:0] iTerm;
	logic signed [47:0] sumTerms;
	logic signed [31:0] unramped_output;
	logic signed [31:0] clamped;
	logic signed [32:0] shaped;
	logic signed [32:0] rampBase;
	logic signed [32:0] slew;
	logic signed [32:0] deltaUp;
	logic signed [32:0] deltaDn;
	logic signed [32:0] outNxt;
	logic [15:0]        slewLimit;
	logic [31:0]        izone;
	logic [15:0]        iGain;

	assign target    = $signed(cfgR[1]);
	assign iGain     = cfgR[3][15:0];
	assign izone     = cfgR[6];
	assign slewLimit = cfgR[7][15:0];
	assign measured  = (mode == pcm_pkg::MODE_VELOCITY) ? vel_r : sensPos;
	assign err       = target - measured;
	assign absErr    = err[31] ? -err : err;

	assign iNxt = !primed_flag_r ? 32'sh0
		: ((izone == 32'h0) || (32'(absErr) < izone)) ? integral_sum_r + err
		: 32'sh0;
	assign dNxt = primed_flag_r ? err - previous_error_r : 32'sh0;
	assign iTerm = ((iNxt != 32'sh0) && (iGain != 16'h0))
		? mulGain(iNxt, {1'b0, iGain}) : 48'sh0;
	assign sumTerms = mulGain(err, {1'b0, cfgR[2][15:0]})
		+ iTerm
		+ mulGain(dNxt, {1'b0, cfgR[4][15:0]})
		+ mulGain(target, {cfgR[5][15], cfgR[5][15:0]});
	assign unramped_output = sat32(sumTerms);
	assign clamped = (posOnly && unramped_output[31])
		? 32'sh0 : unramped_output;
	assign shaped = outInv ? -33'(clamped) : 33'(clamped);

	assign rampBase = primed_flag_r ? loopOut_r
		: 33'($signed(throttle));
	assign slew     = $signed({17'h0, slewLimit});
	assign deltaUp  = (shaped - rampBase > slew) ? slew : shaped - rampBase;
	assign deltaDn  = (rampBase - shaped > slew) ? slew : rampBase - shaped;
	assign outNxt   = (slewLimit == 16'h0) ? shaped
		: (shaped >= rampBase) ? rampBase + deltaUp
		: rampBase - deltaDn;

	always_ff @(posedge ref_clk)
	begin
		if (rst || !loopMode || reinit)
		begin
			primed_flag_r    <= 1'b0;
			integral_sum_r   <= '0;
			error_delta_r    <= '0;
			previous_error_r <= '0;
			loopOut_r        <= '0;
		end
		else if (loopTick)
		begin
			integral_sum_r   <= iNxt;
			error_delta_r    <= dNxt;
			previous_error_r <= err;
			loopOut_r        <= outNxt;
			primed_flag_r    <= 1'b1;
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
			error_r <= '0;
		else if (loopMode && loopTick)
			error_r <= err;
	end

	assign loopError = error_r;

	// open-loop ramp and final throttle
	logic signed [10:0] openThrot_r;
	logic signed [10:0] throttle_r;
	logic signed [10:0] openCmd;
	logic signed [32:0] openDiff;
	logic signed [32:0] openStep;
	logic signed [32:0] leaderSigned;
	logic [15:0]        openRamp;

	assign openRamp = cfgR[8][15:0];
	assign openCmd  = satThrot(33'($signed(cfgR[9][10:0])));
	assign openDiff = 33'(openCmd) - 33'(openThrot_r);
	assign openStep = (openDiff > $signed({17'h0, openRamp}))
		? $signed({17'h0, openRamp})
		: (openDiff < -$signed({17'h0, openRamp}))
		? -$signed({17'h0, openRamp}) : openDiff;
	assign leaderSigned = outInv ? -33'($signed(leaderThrottle))
		: 33'($signed(leaderThrottle));

	always_ff @(posedge ref_clk)
	begin
		if (rst)
			openThrot_r <= '0;
		else if (openRamp == 16'h0)
			openThrot_r <= openCmd;
		else if (rampTick)
			openThrot_r <= satThrot(33'(openThrot_r) + openStep);
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
			throttle_r <= '0;
		else
		begin
			case (mode)
				pcm_pkg::MODE_OPEN:   throttle_r <= openThrot_r;
				pcm_pkg::MODE_FOLLOW:
					throttle_r <= satThrot(leaderSigned);
				default:              throttle_r <= satThrot(loopOut_r);
			endcase
		end
	end

	assign throttle = throttle_r;

	// axi4-lite slave
	logic        awHeld_r;
	logic [7:0]  awAddr_r;
	logic        wHeld_r;
	logic [31:0] wData_r;
	logic [3:0]  wStrb_r;
	logic        bvalid_r;
	logic [1:0]  bresp_r;
	logic        rvalid_r;
	logic [31:0] rdata_r;
	logic [1:0]  rresp_r;
	logic        doWrite;
	logic [3:0]  wrIdx;
	logic        wrOk;
	logic [31:0] strbMask;
	logic [31:0] wrMask;
	logic [3:0]  rdIdx;
	logic        rdOk;

	assign s_axi_awready = !awHeld_r;
	assign s_axi_wready  = !wHeld_r;
	assign s_axi_bvalid  = bvalid_r;
	assign s_axi_bresp   = bresp_r;
	assign s_axi_arready = !rvalid_r;
	assign s_axi_rvalid  = rvalid_r;
	assign s_axi_rdata   = rdata_r;
	assign s_axi_rresp   = rresp_r;

	assign doWrite  = awHeld_r && wHeld_r && !bvalid_r;
	assign wrIdx    = awAddr_r[5:2];
	assign wrOk     = (awAddr_r[7:6] == 2'h0)
		&& (32'(wrIdx) <= 32'(pcm_pkg::LAST_RW_IDX));
	assign strbMask = {{8{wStrb_r[3]}}, {8{wStrb_r[2]}},
		{8{wStrb_r[1]}}, {8{wStrb_r[0]}}};
	assign wrMask   = (wrIdx == 4'h0) ? pcm_pkg::CTRL_MASK
		: (wrIdx == 4'h9) ? 32'h0000_07FF : 32'hFFFF_FFFF;
	assign reinit   = doWrite && wrOk && (wrIdx == 4'h0)
		&& wStrb_r[0] && wData_r[pcm_pkg::CTRL_REINIT];
	assign rdIdx    = s_axi_araddr[5:2];
	assign rdOk     = s_axi_araddr[7:6] == 2'h0;

	genvar gi;
	generate
		for (gi = 0; gi <= pcm_pkg::LAST_RW_IDX; gi++)
		begin : gView
			assign regView[gi] = cfgR[gi];
		end
	endgenerate
	assign regView[10] = quadPos_r;
	assign regView[11] = vel_r;
	assign regView[12] = error_r;
	assign regView[13] = 32'($signed(throttle_r));
	assign regView[14] = integral_sum_r;
	assign regView[15] = {31'h0, primed_flag_r};

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			awHeld_r <= 1'b0;
			awAddr_r <= '0;
			wHeld_r  <= 1'b0;
			wData_r  <= '0;
			wStrb_r  <= '0;
			bvalid_r <= 1'b0;
			bresp_r  <= pcm_pkg::RESP_OKAY;
		end
		else
		begin
			if (s_axi_awvalid && !awHeld_r)
			begin
				awHeld_r <= 1'b1;
				awAddr_r <= s_axi_awaddr;
			end
			else if (doWrite)
				awHeld_r <= 1'b0;
			if (s_axi_wvalid && !wHeld_r)
			begin
				wHeld_r <= 1'b1;
				wData_r <= s_axi_wdata;
				wStrb_r <= s_axi_wstrb;
			end
			else if (doWrite)
				wHeld_r <= 1'b0;
			if (doWrite)
			begin
				bvalid_r <= 1'b1;
				bresp_r  <= wrOk ? pcm_pkg::RESP_OKAY : pcm_pkg::RESP_SLVERR;
			end
			else if (s_axi_bready)
				bvalid_r <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			for (int i = 0; i <= pcm_pkg::LAST_RW_IDX; i++)
				cfgR[i] <= pcm_pkg::REG_RESET;
		end
		else if (doWrite && wrOk)
			cfgR[wrIdx] <= ((cfgR[wrIdx] & ~strbMask)
				| (wData_r & strbMask)) & wrMask;
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			rvalid_r <= 1'b0;
			rdata_r  <= '0;
			rresp_r  <= pcm_pkg::RESP_OKAY;
		end
		else if (s_axi_arvalid && !rvalid_r)
		begin
			rvalid_r <= 1'b1;
			rdata_r  <= rdOk ? regView[rdIdx] : 32'h0;
			rresp_r  <= rdOk ? pcm_pkg::RESP_OKAY : pcm_pkg::RESP_SLVERR;
		end
		else if (s_axi_rready)
			rvalid_r <= 1'b0;
	end

endmodule: pcm_motor_core

// file: pcm_pkg.sv
// shared constants, register map and mode types for the motor core
package pcm_pkg;

	// clock rate and periodic step times
	localparam int CLK_MHZ        = 200;
	localparam int LOOP_PERIOD_US = 1;
	localparam int LOOP_PERIOD_MS = 1;
	localparam int RAMP_PERIOD_MS = 10;
	localparam int VEL_WINDOW_MS  = 100;
	localparam int CYCLES_PER_MS  = CLK_MHZ * 1000;
	localparam int LOOP_CYCLES    = LOOP_PERIOD_MS * CYCLES_PER_MS;
	localparam int RAMP_CYCLES    = RAMP_PERIOD_MS * CYCLES_PER_MS;
	localparam int VEL_CYCLES     = VEL_WINDOW_MS * CYCLES_PER_MS;

	// widths
	localparam int ADDR_W  = 8;
	localparam int DATA_W  = 32;
	localparam int ADC_W   = 10;
	localparam int THR_W   = 11;
	localparam int GAIN_W  = 16;
	localparam int REG_NUM = 16;

	// throttle full scale and arithmetic limits
	localparam int THROT_MAX = 1023;
	localparam logic signed [47:0] S32_MAX = 48'sh0000_7FFF_FFFF;
	localparam logic signed [47:0] S32_MIN = 48'shFFFF_8000_0000;

	// register byte offsets
	localparam logic [7:0] OFF_CTRL     = 8'h00;
	localparam logic [7:0] OFF_TARGET   = 8'h04;
	localparam logic [7:0] OFF_PGAIN    = 8'h08;
	localparam logic [7:0] OFF_IGAIN    = 8'h0C;
	localparam logic [7:0] OFF_DGAIN    = 8'h10;
	localparam logic [7:0] OFF_FGAIN    = 8'h14;
	localparam logic [7:0] OFF_IZONE    = 8'h18;
	localparam logic [7:0] OFF_SLEW     = 8'h1C;
	localparam logic [7:0] OFF_OPENRAMP = 8'h20;
	localparam logic [7:0] OFF_OPENCMD  = 8'h24;
	localparam logic [7:0] OFF_POSITION = 8'h28;
	localparam logic [7:0] OFF_VELOCITY = 8'h2C;
	localparam logic [7:0] OFF_ERROR    = 8'h30;
	localparam logic [7:0] OFF_THROTTLE = 8'h34;
	localparam logic [7:0] OFF_INTEGRAL = 8'h38;
	localparam logic [7:0] OFF_STATUS   = 8'h3C;
	localparam int LAST_RW_IDX = 9;

	// control register fields
	localparam int CTRL_MODE_LSB  = 0;
	localparam int CTRL_SENS_LSB  = 2;
	localparam int CTRL_SENS_INV  = 4;
	localparam int CTRL_OUT_INV   = 5;
	localparam int CTRL_POS_ONLY  = 6;
	localparam int CTRL_REINIT    = 7;
	localparam logic [31:0] CTRL_MASK = 32'h0000_007F;

	// reset values and bus answers
	localparam logic [31:0] REG_RESET = 32'h0000_0000;
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;

	typedef enum logic [1:0]
	{
		MODE_OPEN     = 2'b00,
		MODE_POSITION = 2'b01,
		MODE_VELOCITY = 2'b10,
		MODE_FOLLOW   = 2'b11
	} pcm_mode_e;

	typedef enum logic [1:0]
	{
		SENS_QUAD   = 2'b00,
		SENS_RISE   = 2'b01,
		SENS_POT    = 2'b10,
		SENS_ANALOG = 2'b11
	} pcm_sensor_e;

endpackage: pcm_pkg

// file: pcm_pin_sync.sv
// three-stage pin synchroniser that accepts a change once the last two stages agree
`timescale 1ns/1ps
module pcm_pin_sync
#(
	parameter int WIDTH = 2
)
(
	// clock and reset
	input  logic             clk,
	input  logic             rst,
	// pins and filtered levels
	input  logic [WIDTH-1:0] pinIn,
	output logic [WIDTH-1:0] pinOut
);

	logic [WIDTH-1:0] stage1_r;
	logic [WIDTH-1:0] stage2_r;
	logic [WIDTH-1:0] stage3_r;
	logic [WIDTH-1:0] level_r;
	logic [WIDTH-1:0] agree;

	assign agree  = ~(stage2_r ^ stage3_r);
	assign pinOut = level_r;

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			stage1_r <= '0;
			stage2_r <= '0;
			stage3_r <= '0;
			level_r  <= '0;
		end
		else
		begin
			stage1_r <= pinIn;
			stage2_r <= stage1_r;
			stage3_r <= stage2_r;
			level_r  <= (agree & stage3_r) | (~agree & level_r);
		end
	end

endmodule: pcm_pin_sync

// file: pcm_motor_core_assertions.sv
// bus handshake and loop timing checks bound onto the motor core
`timescale 1ns/1ps
module pcm_motor_core_chk
#(
	parameter int unsigned LOOP_CYCLES = 20
)
(
	// clock and reset
	input wire logic        ref_clk,
	input wire logic        rst,
	// register bus
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	// loop outputs
	input wire logic [10:0] throttle,
	input wire logic [31:0] loopError,
	input wire logic        loopTick
);
	int unsigned gap_r;
	logic        seen_r;

	// cycles since the last loop pass
	always_ff @(posedge ref_clk)
	begin
		gap_r <= (rst || loopTick) ? 0 : gap_r + 1;
		seen_r <= rst ? 1'b0 : (seen_r || loopTick);
	end

	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);

	sequence s_wr_both;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_rd_take;
		s_axi_arvalid && s_axi_arready;
	endsequence

	a_thr_range: assert property (throttle != 11'h400)
		else $error("throttle beyond full scale");
	a_tick_gap: assert property (seen_r |->
		(loopTick == (gap_r == LOOP_CYCLES - 1)))
		else $error("loop pass spacing wrong");
	a_err_on_pass: assert property (!$stable(loopError) |->
		$past(loopTick))
		else $error("loop error moved outside a pass");
	a_wr_answer: assert property ((s_wr_both and !s_axi_bvalid) |=>
		##1 s_axi_bvalid)
		else $error("write answer late");
	a_rd_answer: assert property (s_rd_take |=> s_axi_rvalid)
		else $error("read answer late");
	a_rd_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer dropped");
	a_wr_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write answer dropped");
	a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("address taken while answer pending");
	a_aw_block: assert property (s_axi_awvalid && s_axi_awready |=>
		!s_axi_awready)
		else $error("second write address taken");
endmodule: pcm_motor_core_chk

bind pcm_motor_core pcm_motor_core_chk #(.LOOP_CYCLES(LOOP_CYCLES))
	pcm_motor_core_chk_inst (.ref_clk(ref_clk), .rst(rst),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.throttle(throttle), .loopError(loopError), .loopTick(loopTick));

// file: pcm_sensor_model.sv
// encoder and converter model feeding the motor core
`timescale 1ns/1ps
module pcm_sensor_model
(
	// clock
	input wire logic ref_clk,
	// encoder phases and converter sample
	output logic       quadAPin,
	output logic       quadBPin,
	output logic [9:0] adcData,
	output logic       adcValid
);
	int   ph = 0;
	int   dv = 0;
	logic run = 1'b0;

	initial
	begin
		quadAPin = 1'b0;
		quadBPin = 1'b0;
		adcData = 10'h000;
		adcValid = 1'b0;
	end

	// phase order 00,10,11,01: A leads B going forward
	task mv(input bit fwd);
		ph = fwd ? (ph + 1) % 4 : (ph + 3) % 4;
		quadAPin <= (ph == 1 || ph == 2);
		quadBPin <= (ph >= 2);
	endtask: mv

	task step(input int n, input bit fwd);
		repeat (n)
		begin
			repeat (6) @(posedge ref_clk);
			mv(fwd);
		end
		repeat (8) @(posedge ref_clk);
	endtask: step

	// data inverted once valid drops
	task sample(input logic [9:0] d);
		@(posedge ref_clk);
		adcData <= d;
		adcValid <= 1'b1;
		@(posedge ref_clk);
		adcData <= ~d;
		adcValid <= 1'b0;
	endtask: sample

	// free run: one edge every 5 cycles
	always @(posedge ref_clk)
	begin
		dv = run ? (dv + 1) % 5 : 0;
		if (run && dv == 0)
			mv(1'b1);
	end
endmodule: pcm_sensor_model

// file: pcm_motor_core_tb.sv
// register-level testbench for the motor core
`timescale 1ns/1ps
module pcm_motor_core_tb;
	logic        ref_clk, rst, awv, awr, wv, wr, bv, br, arv, arr, rv, rr;
	logic        qa, qb, av, tk;
	logic [7:0]  awa, ara;
	logic [31:0] wd, rd, le, v, w;
	logic [3:0]  ws, st;
	logic [1:0]  bre, rre, r;
	logic [9:0]  ad;
	logic [10:0] lt, th;
	int          errors, num_checks, c;

	pcm_motor_core #(.LOOP_CYCLES(20), .RAMP_CYCLES(200), .VEL_CYCLES(100))
	pcm_motor_core_inst (.ref_clk(ref_clk), .rst(rst), .s_axi_awaddr(awa),
		.s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
		.s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wr),
		.s_axi_bresp(bre), .s_axi_bvalid(bv), .s_axi_bready(br),
		.s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
		.s_axi_rdata(rd), .s_axi_rresp(rre), .s_axi_rvalid(rv),
		.s_axi_rready(rr), .quadAPin(qa), .quadBPin(qb), .adcData(ad),
		.adcValid(av), .leaderThrottle(lt), .throttle(th),
		.loopError(le), .loopTick(tk));
	pcm_sensor_model pcm_sensor_model_inst (.ref_clk(ref_clk),
		.quadAPin(qa), .quadBPin(qb), .adcData(ad), .adcValid(av));

	initial
	begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end

	function logic [31:0] sx(input logic [10:0] x);
		return {{21{x[10]}}, x};
	endfunction: sx

	task chk(input string n, input logic [31:0] s, input logic [31:0] e);
		num_checks++;
		if (s !== e)
		begin
			errors++;
			$display("BAD %s exp %0h seen %0h", n, e, s);
		end
	endtask: chk

	// handshakes sampled at the rising edge, released just after it
	task wreg(input logic [7:0] a, input logic [31:0] d);
		logic ha, hw, hb;
		hb = 1'b0;
		c = 0;
		awa <= a;
		wd <= d;
		ws <= st;
		awv <= 1'b1;
		wv <= 1'b1;
		br <= 1'b1;
		while (!hb && c < 99)
		begin
			@(posedge ref_clk);
			ha = awv && awr;
			hw = wv && wr;
			hb = bv && br;
			r = bre;
			c++;
			if (ha)
				awv <= 1'b0;
			if (hw)
				wv <= 1'b0;
		end
		if (!hb)
			errors++;
	endtask: wreg

	task rreg(input logic [7:0] a);
		logic ha, hr;
		hr = 1'b0;
		c = 0;
		ara <= a;
		arv <= 1'b1;
		rr <= 1'b1;
		while (!hr && c < 99)
		begin
			@(posedge ref_clk);
			ha = arv && arr;
			hr = rv && rr;
			v = rd;
			r = rre;
			c++;
			if (ha)
				arv <= 1'b0;
		end
		if (!hr)
			errors++;
	endtask: rreg

	task ticks(input int k);
		repeat (k) @(posedge ref_clk iff tk);
		repeat (3) @(posedge ref_clk);
	endtask: ticks

	task chg();
		logic [10:0] o;
		o = th;
		c = 0;
		while (th === o && c < 999)
		begin
			@(posedge ref_clk);
			c++;
		end
	endtask: chg

	task velc(input logic [31:0] ctl, input logic [31:0] e);
		wreg(8'h00, ctl);
		repeat (350) @(posedge ref_clk);
		rreg(8'h2C);
		chk("velocity", v, e);
	endtask: velc

	task test_done();
		$display("checks %0d mismatches %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask: test_done

	initial
	begin
		repeat (20000) @(posedge ref_clk);
		errors++;
		test_done();
	end

	initial
	begin
		errors = 0;
		num_checks = 0;
		rst = 1'b1;
		{awv, wv, br, arv, rr, awa, ara, wd} = '0;
		{ws, st} = 8'hFF;
		lt = 11'h000;
		repeat (6) @(posedge ref_clk);
		rst <= 1'b0;
		rreg(8'h00);
		chk("ctrl reset", v, 0);
		chk("throttle reset", sx(th), 0);
		rreg(8'h40);
		chk("unmapped read", {v[31:2], r}, 32'h2);
		wreg(8'h28, 1);
		chk("read-only write", {30'h0, r}, 32'h2);
		st = 4'h2;
		wreg(8'h18, 32'hAABBCCDD);
		st = 4'hF;
		rreg(8'h18);
		chk("strobe merge", v, 32'h0000CC00);
		$display("test bus done");
		wreg(8'h24, 32'h1F4);
		repeat (4) @(posedge ref_clk);
		chk("open command", sx(th), 32'h1F4);
		wreg(8'h24, 32'h400);
		repeat (4) @(posedge ref_clk);
		chk("open saturate", sx(th), -1023);
		wreg(8'h20, 10);
		wreg(8'h24, 0);
		chg();
		chk("ramp first", sx(th), -1013);
		chg();
		chk("ramp second", sx(th), -1003);
		chk("ramp period", c, 200);
		wreg(8'h20, 0);
		repeat (4) @(posedge ref_clk);
		chk("ramp off", sx(th), 0);
		$display("test open loop done");
		pcm_sensor_model_inst.step(8, 1'b1);
		rreg(8'h28);
		chk("quad forward", v, 8);
		pcm_sensor_model_inst.step(3, 1'b0);
		rreg(8'h28);
		chk("quad reverse", v, 5);
		pcm_sensor_model_inst.run = 1'b1;
		velc(32'h00, 20);
		velc(32'h10, -20);
		velc(32'h06, 5);
		chk("vel error", le, -5);
		pcm_sensor_model_inst.run = 1'b0;
		$display("test sensors done");
		pcm_sensor_model_inst.sample(10'h3FF);
		wreg(8'h08, 1);
		wreg(8'h04, 1000);
		@(posedge ref_clk iff tk);
		wreg(8'h00, 32'h89);
		rreg(8'h3C);
		chk("reinit", v, 0);
		ticks(3);
		chk("loop error", le, -23);
		chk("p output", sx(th), -23);
		rreg(8'h3C);
		chk("primed", v, 1);
		@(posedge ref_clk iff tk);
		rreg(8'h38);
		w = v;
		@(posedge ref_clk iff tk);
		rreg(8'h38);
		chk("integral step", v - w, -23);
		wreg(8'h0C, 1);
		@(posedge ref_clk iff tk);
		rreg(8'h38);
		chk("i term", sx(th), v - 32'd23);
		wreg(8'h0C, 0);
		wreg(8'h18, 23);
		ticks(2);
		rreg(8'h38);
		chk("izone clear", v, 0);
		wreg(8'h00, 32'h69);
		ticks(2);
		chk("clamp then invert", sx(th), 0);
		wreg(8'h00, 32'h29);
		ticks(2);
		chk("invert output", sx(th), 23);
		$display("test pid done");
		wreg(8'h00, 32'h09);
		wreg(8'h08, 0);
		wreg(8'h10, 1);
		@(posedge ref_clk iff tk);
		wreg(8'h04, 1010);
		@(posedge ref_clk iff tk);
		repeat (3) @(posedge ref_clk);
		chk("d term", sx(th), 10);
		wreg(8'h10, 0);
		wreg(8'h1C, 5);
		wreg(8'h14, 32'hFFFF);
		ticks(1);
		w = sx(th);
		ticks(1);
		chk("slew step", sx(th) - w, -5);
		wreg(8'h1C, 0);
		ticks(2);
		chk("feed forward", sx(th), -1010);
		wreg(8'h14, 0);
		wreg(8'h08, 1);
		wreg(8'h04, 0);
		wreg(8'h00, 32'h0D);
		pcm_sensor_model_inst.sample(10'd1000);
		pcm_sensor_model_inst.sample(10'd10);
		ticks(2);
		chk("unwrap", le, -1034);
		lt <= 11'd300;
		wreg(8'h00, 32'h23);
		repeat (4) @(posedge ref_clk);
		chk("follower invert", sx(th), -300);
		$display("test slew and follower done");
		test_done();
	end
endmodule: pcm_motor_core_tb
